// ==== common/xcs_pkg.sv ====
package xcs_pkg;

   // ------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W      = 16;
   localparam int unsigned DATA_W      = 32;

   // ------------------------------------------------------------
   // Address map of the block's slave window (byte addresses)
   // ------------------------------------------------------------
   localparam int unsigned ALIAS_BYTES = 16384;                 // 16 kB data array
   localparam int unsigned ALIAS_WORDS = ALIAS_BYTES / 4;
   localparam int unsigned ALIAS_IDX_W = 12;
   localparam int unsigned ALIAS_IDX_LO = 2;
   localparam logic [15:0] ALIAS_LIMIT = 16'h4000;              // first byte past alias
   localparam logic [15:0] CTRL_OFS    = 16'h4000;
   localparam logic [15:0] FLUSH_OFS   = 16'h4004;

   // ------------------------------------------------------------
   // Control register fields and reset values
   // ------------------------------------------------------------
   localparam int unsigned CTRL_EN_BIT   = 0;
   localparam int unsigned CTRL_BUSY_BIT = 1;
   localparam logic        EN_RESET      = 1'b1;
   localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

   // ------------------------------------------------------------
   // Tag memory flush
   // ------------------------------------------------------------
   localparam int unsigned TAG_LINES  = 512;
   localparam int unsigned TAG_IDX_W  = 9;
   localparam logic [8:0]  TAG_LAST   = 9'h1FF;
   localparam logic [8:0]  TAG_FIRST  = 9'h000;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [31:0] wdata;
   } xcs_req_s;

   typedef struct packed {
      logic        ready;
      logic        err;
      logic [31:0] rdata;
   } xcs_resp_s;

   localparam xcs_resp_s RESP_IDLE = '{ready: 1'b0, err: 1'b0, rdata: 32'h0000_0000};

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RESP = 2'b01,
      ST_WAIT = 2'b10
   } xcs_state_e;

endpackage : xcs_pkg

// ==== hdl/xcs_tag_flush.sv ====
module xcs_tag_flush (
   input  wire logic                       clock,  // system clock
   input  wire logic                       rst,    // sync reset, active high
   input  wire logic                       ce,     // clock enable
   input  wire logic                       start,  // hold or pulse to (re)start a sweep
   output logic                            busy,   // sweep in progress
   output logic [xcs_pkg::TAG_IDX_W-1:0]   line    // tag line being invalidated
);
   import xcs_pkg::*;

   // ------------------------------------------------------------
   // Sweep
   // ------------------------------------------------------------
   // Held at line 0 while start stays high, so the walk begins after release
   wire logic             last_line = (line == TAG_LAST);
   wire logic [8:0]       line_inc  = line + 9'h001;

   always_ff @(posedge clock) begin
      if (rst) begin
         busy <= 1'b0;
         line <= TAG_FIRST;
      end else if (ce) begin
         if (start) begin
            busy <= 1'b1;
            line <= TAG_FIRST;
         end else if (busy) begin
            busy <= !last_line;
            line <= last_line ? TAG_FIRST : line_inc;
         end
      end
   end

endmodule : xcs_tag_flush

// ==== hdl/xcs_cache_ctrl.sv ====
module xcs_cache_ctrl (
   input  wire logic               clock,      // system clock, 10 MHz
   input  wire logic               rst,        // chip reset, sync, active high
   input  wire logic               wdog_rst,   // watchdog reset, sync, active high
   input  wire logic               ce,         // clock enable, freezes all state when low
   input  wire xcs_pkg::xcs_req_s  req,        // bus request, held until ready
   output xcs_pkg::xcs_resp_s      resp,       // bus response, ready pulses one cycle
   output logic                    cache_en,   // caching enabled
   output logic                    flush_busy  // tag flush in progress
);
   import xcs_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   xcs_state_e       state_reg;
   xcs_state_e       state_next;
   xcs_resp_s        resp_reg;
   xcs_resp_s        resp_next;
   logic             en_reg;
   logic [31:0]      mem [0:ALIAS_WORDS-1];
   logic [TAG_IDX_W-1:0] flush_line;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire logic        any_rst    = rst || wdog_rst;
   wire logic        idle       = (state_reg == ST_IDLE);
   wire logic        take       = ce && idle && req.valid && !any_rst;
   wire logic        hit_alias  = (req.addr < ALIAS_LIMIT);
   wire logic        hit_ctrl   = (req.addr == CTRL_OFS);
   wire logic        hit_flush  = (req.addr == FLUSH_OFS);
   wire logic        miss       = !(hit_alias || hit_ctrl || hit_flush);
   wire logic        alias_err  = hit_alias && en_reg;
   wire logic        alias_ok   = hit_alias && !en_reg;
   wire logic [ALIAS_IDX_W-1:0] alias_idx = req.addr[ALIAS_IDX_LO +: ALIAS_IDX_W];
   wire logic        mem_we     = take && alias_ok && req.write;
   wire logic        ctrl_we    = take && hit_ctrl && req.write;
   wire logic        flush_we   = take && hit_flush && req.write;
   // Reading the flush register waits out a running sweep
   wire logic        flush_hold = take && hit_flush && !req.write && flush_busy;
   wire logic        flush_start = wdog_rst || flush_we;

   wire logic [31:0] ctrl_word  = {30'h0000_0000, flush_busy, en_reg};
   wire logic [31:0] read_word  = hit_ctrl  ? ctrl_word :
                                  alias_ok  ? mem[alias_idx] : DATA_ZERO;
   wire logic        resp_err   = miss || alias_err;

   // ------------------------------------------------------------
   // Next state and response
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      resp_next  = RESP_IDLE;
      case (state_reg)
         ST_IDLE: begin
            if (flush_hold) begin
               state_next = ST_WAIT;
            end else if (take) begin
               state_next      = ST_RESP;
               resp_next.ready = 1'b1;
               resp_next.err   = resp_err;
               resp_next.rdata = (req.write || resp_err) ? DATA_ZERO : read_word;
            end
         end
         ST_RESP: begin
            // Requester drops valid on seeing ready; this cycle keeps it from re-taking
            state_next = ST_IDLE;
         end
         ST_WAIT: begin
            if (!flush_busy) begin
               state_next      = ST_RESP;
               resp_next.ready = 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (any_rst) begin
         state_reg <= ST_IDLE;
         resp_reg  <= RESP_IDLE;
      end else if (ce) begin
         state_reg <= state_next;
         resp_reg  <= resp_next;
      end
   end

   always_ff @(posedge clock) begin
      if (any_rst) begin
         en_reg <= EN_RESET;
      end else if (ce && ctrl_we) begin
         en_reg <= req.wdata[CTRL_EN_BIT];
      end
   end

   // No reset on the array so contents survive either reset
   always_ff @(posedge clock) begin
      if (ce && mem_we) begin
         mem[alias_idx] <= req.wdata;
      end
   end

   xcs_tag_flush u_flush (
      .clock (clock),
      .rst   (rst),
      .ce    (ce),
      .start (flush_start),
      .busy  (flush_busy),
      .line  (flush_line)
   );

   assign resp     = resp_reg;
   assign cache_en = en_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   logic [8:0] flush_line_seen;
   assign flush_line_seen = flush_line;

   a_alias_err_en: assert property (@(posedge clock) disable iff (any_rst)
      take && hit_alias && en_reg |=> resp.ready && resp.err && resp.rdata == DATA_ZERO)
      else $error("alias access while enabled not refused");

   a_alias_no_write: assert property (@(posedge clock) disable iff (rst)
      take && alias_err && req.write |=> mem[$past(alias_idx)] == $past(mem[alias_idx]))
      else $error("alias written while caching enabled");

   a_alias_ok_dis: assert property (@(posedge clock) disable iff (any_rst)
      take && hit_alias && !en_reg && !req.write ##1 1'b1
      |-> resp.ready && !resp.err && resp.rdata == mem[$past(alias_idx)])
      else $error("alias read while disabled returned wrong data");

   a_wdog_en: assert property (@(posedge clock) disable iff (rst)
      wdog_rst |=> cache_en)
      else $error("watchdog reset left caching disabled");

   a_wdog_flush: assert property (@(posedge clock) disable iff (rst)
      wdog_rst && ce |=> flush_busy && flush_line_seen == TAG_FIRST)
      else $error("watchdog reset did not start tag flush");

   a_flush_stall: assert property (@(posedge clock) disable iff (any_rst)
      flush_hold |=> !resp.ready throughout (state_reg == ST_WAIT && flush_busy)[*1])
      else $error("flush read answered during flush");

   a_wait_release: assert property (@(posedge clock) disable iff (any_rst)
      state_reg == ST_WAIT && !flush_busy && ce |=> resp.ready && !resp.err)
      else $error("flush read not answered after flush");

   a_resp_pulse: assert property (@(posedge clock) disable iff (any_rst)
      resp.ready && ce |=> !resp.ready)
      else $error("ready held beyond one cycle");

   a_miss_err: assert property (@(posedge clock) disable iff (any_rst)
      take && miss |=> resp.ready && resp.err)
      else $error("unmapped address not refused");

   a_ctrl_write: assert property (@(posedge clock) disable iff (any_rst)
      ctrl_we |=> cache_en == $past(req.wdata[CTRL_EN_BIT]))
      else $error("enable bit not taken from write");

   c_alias_refused: cover property (@(posedge clock) disable iff (any_rst)
      take && alias_err);
   c_alias_used: cover property (@(posedge clock) disable iff (any_rst)
      mem_we ##[1:20] take && alias_ok && !req.write);
   c_flush_wait: cover property (@(posedge clock) disable iff (any_rst)
      state_reg == ST_WAIT ##1 resp.ready);
   c_wdog_flush: cover property (@(posedge clock) disable iff (rst)
      wdog_rst ##1 flush_busy);
   c_ce_hold: cover property (@(posedge clock) disable iff (any_rst)
      !ce && flush_busy);

   // Sweep length kept in a counter: far too long for a repetition
   logic [9:0] sweep_cnt_reg;

   always_ff @(posedge clock) begin
      if (rst || (flush_start && ce) || !flush_busy) begin
         sweep_cnt_reg <= 10'h000;
      end else if (ce) begin
         sweep_cnt_reg <= sweep_cnt_reg + 10'h001;
      end
   end

   a_sweep_len: assert property (@(posedge clock) disable iff (any_rst)
      flush_busy |-> sweep_cnt_reg < TAG_LINES)
      else $error("tag flush ran past the last line");

   a_sweep_end: assert property (@(posedge clock) disable iff (any_rst)
      $fell(flush_busy) && !$past(any_rst) |-> $past(sweep_cnt_reg) == 10'(TAG_LINES - 1))
      else $error("tag flush ended early");

   a_flush_write: assert property (@(posedge clock) disable iff (any_rst)
      flush_we |=> flush_busy && flush_line_seen == TAG_FIRST)
      else $error("flush write did not restart the sweep");

   a_ce_freeze: assert property (@(posedge clock) disable iff (any_rst)
      !ce |=> $stable(resp) && $stable(cache_en) && $stable(flush_busy))
      else $error("state moved while clock enable low");

   a_wr_rdata_zero: assert property (@(posedge clock) disable iff (any_rst)
      take && req.write |=> resp.ready && resp.rdata == DATA_ZERO)
      else $error("write answered with nonzero data");

endmodule : xcs_cache_ctrl

// ==== tb/xcs_bus_master.sv ====
module xcs_bus_master (
   input  wire logic                clock,  // system clock
   input  wire xcs_pkg::xcs_resp_s  resp,   // answer from the block
   output xcs_pkg::xcs_req_s        req     // request toward the block
);
   timeunit 1ns;
   timeprecision 1ns;
   import xcs_pkg::*;

   initial req = '0;

   // ------------------------------------------------------------
   // One word transfer, held until ready is sampled
   // ------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       output logic err, output logic [31:0] rd, output int cyc);
      @(posedge clock);
      #10;
      req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
      cyc = -1;
      err = 1'b0;
      rd = DATA_ZERO;
      for (int i = 1; i <= 600; i++) begin
         @(posedge clock);
         if (resp.ready === 1'b1) begin
            err = resp.err;
            rd = resp.rdata;
            cyc = i;
            break;
         end
      end
      #10;
      // Released lines flip so stale values cannot pass as live ones
      req = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
   endtask : xfer
endmodule : xcs_bus_master

// ==== tb/xcs_cache_ctrl_bench.sv ====
module xcs_cache_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import xcs_pkg::*;

   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      logic [31:0] wd;
      logic        err;
      logic [31:0] rd;
   } xcs_row_s;

   localparam xcs_row_s ROWS [8] = '{
      '{1'b1, CTRL_OFS, 32'h0, 1'b0, 32'h0},
      '{1'b0, CTRL_OFS, 32'h0, 1'b0, 32'h0},
      '{1'b1, 16'h0000, 32'hA5A5_0001, 1'b0, 32'h0},
      '{1'b1, 16'h3FFC, 32'h5A5A_0002, 1'b0, 32'h0},
      '{1'b0, 16'h0000, 32'h0, 1'b0, 32'hA5A5_0001},
      '{1'b0, 16'h3FFE, 32'h0, 1'b0, 32'h5A5A_0002},
      '{1'b0, 16'h4008, 32'h0, 1'b1, 32'h0},
      '{1'b1, 16'h4008, 32'h1, 1'b1, 32'h0}};

   logic        clock;
   logic        rst;
   logic        wdog_rst;
   logic        ce;
   xcs_req_s    req;
   xcs_resp_s   resp;
   logic        cache_en;
   logic        flush_busy;
   logic        g_err;
   logic [31:0] g_rd;
   int          g_cyc;
   int          n_fail = 0;
   int          n_checks = 0;

   xcs_bus_master u_mst (.clock(clock), .resp(resp), .req(req));
   xcs_cache_ctrl u_dut (.clock(clock), .rst(rst), .wdog_rst(wdog_rst), .ce(ce),
                         .req(req), .resp(resp), .cache_en(cache_en),
                         .flush_busy(flush_busy));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   task automatic chk_bit(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %b want %b", $time, what, got, exp);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk_word

   // Bounded transfer; a hang ends the run as a failure
   task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d);
      u_mst.xfer(wr, a, d, g_err, g_rd, g_cyc);
      if (g_cyc < 0) begin
         n_fail++;
         $display("ERROR %0t no answer at %h", $time, a);
         print_verdict();
      end
   endtask : acc

   initial begin
      rst = 1'b1;
      wdog_rst = 1'b0;
      ce = 1'b1;
      repeat (10) @(posedge clock);
      #10;
      rst = 1'b0;
      chk_bit(cache_en, 1'b1, "enable after reset");
      acc(1'b0, 16'h0000, 32'h0);
      chk_bit(g_err, 1'b1, "alias while cached");
      $display("test reset done");
      foreach (ROWS[i]) begin
         acc(ROWS[i].wr, ROWS[i].addr, ROWS[i].wd);
         chk_bit(g_err, ROWS[i].err, "row error");
         chk_word(g_rd, ROWS[i].rd, "row data");
      end
      $display("test rows done");
      @(posedge clock);
      #10;
      wdog_rst = 1'b1;
      @(posedge clock);
      #10;
      wdog_rst = 1'b0;
      chk_bit(cache_en, 1'b1, "enable after watchdog");
      chk_bit(flush_busy, 1'b1, "flush started");
      acc(1'b0, CTRL_OFS, 32'h0);
      chk_word(g_rd, 32'h0000_0003, "control during flush");
      acc(1'b1, 16'h0000, 32'hDEAD_0003);
      chk_bit(g_err, 1'b1, "alias write while cached");
      // Dummy flush read waits out the sweep before the alias is read back
      acc(1'b0, FLUSH_OFS, 32'h0);
      chk_bit(g_cyc >= 500, 1'b1, "flush read stalled");
      chk_bit(flush_busy, 1'b0, "flush over at answer");
      chk_word(g_rd, DATA_ZERO, "flush read data");
      acc(1'b1, CTRL_OFS, 32'h0);
      acc(1'b0, 16'h0000, 32'h0);
      chk_word(g_rd, 32'hA5A5_0001, "kept word low");
      acc(1'b0, 16'h3FFC, 32'h0);
      chk_word(g_rd, 32'h5A5A_0002, "kept word high");
      $display("test watchdog done");
      // Flush write restarts the sweep; a frozen sweep must still be running afterwards
      acc(1'b1, FLUSH_OFS, 32'h0);
      chk_bit(g_err, 1'b0, "flush write taken");
      chk_bit(flush_busy, 1'b1, "flush write restarts sweep");
      ce = 1'b0;
      repeat (600) @(posedge clock);
      #10;
      chk_bit(flush_busy, 1'b1, "sweep frozen while ce low");
      ce = 1'b1;
      acc(1'b0, FLUSH_OFS, 32'h0);
      chk_bit(g_cyc >= 500, 1'b1, "frozen sweep resumes");
      chk_bit(flush_busy, 1'b0, "sweep over at answer");
      $display("test ce freeze done");
      print_verdict();
   end
endmodule : xcs_cache_ctrl_bench
